// *** common/pcc_pkg.sv ***
// shared constants for the pll and master clock configuration block
package pcc_pkg;

	// register byte offsets on the avalon slave
	localparam int PCC_ADDR_W = 6;
	localparam logic [5:0] PCC_PLL_A_CONFIG = 6'h00;
	localparam logic [5:0] PCC_PLL_B_CONFIG = 6'h04;
	localparam logic [5:0] PCC_MASTER_CLOCK_SELECT = 6'h08;
	localparam logic [5:0] PCC_PROG_CLOCK0 = 6'h0c;
	localparam logic [5:0] PCC_PROG_CLOCK3 = 6'h18;
	localparam logic [5:0] PCC_INTERRUPT_ENABLE_SET = 6'h1c;
	localparam logic [5:0] PCC_INTERRUPT_DISABLE = 6'h20;
	localparam logic [5:0] PCC_INTERRUPT_MASK = 6'h24;
	localparam logic [5:0] PCC_POWER_STATUS = 6'h28;
	localparam logic [5:0] PCC_EVENT_STATUS = 6'h2c;
	localparam logic [5:0] PCC_EVENT_CLEAR = 6'h30;

	// pll configuration field layout
	localparam int PCC_DIV_LSB = 0;
	localparam int PCC_CNT_LSB = 8;
	localparam int PCC_RANGE_LSB = 14;
	localparam int PCC_MUL_LSB = 16;
	localparam int PCC_USB_BIT = 28;
	localparam logic [31:0] PCC_PLL_A_MASK = 32'h07ff_ffff;
	localparam logic [31:0] PCC_PLL_B_MASK = 32'h17ff_ffff;

	// master and programmable clock field layout
	localparam int PCC_CSS_LSB = 0;
	localparam int PCC_CLOCK_PRESCALER_LSB = 2;
	localparam int PCC_PROCESSOR_RATIO_LSB = 8;
	localparam logic [31:0] PCC_MCKR_MASK = 32'h0000_031f;
	localparam logic [4:0] PCC_PCK_RESET = 5'h00;
	localparam logic [31:0] PCC_REG_RESET = 32'h0000_0000;
	localparam logic [2:0] PCC_CLOCK_PRESCALER_RESERVED = 3'h7;

	// interrupt and status bit positions
	localparam int PCC_FLAG_W = 12;
	localparam int PCC_OSC_BIT = 0;
	localparam int PCC_LOCK_A_BIT = 1;
	localparam int PCC_LOCK_B_BIT = 2;
	localparam int PCC_MCK_RDY_BIT = 3;
	localparam int PCC_PCK_RDY_LSB = 8;
	localparam logic [11:0] PCC_FLAG_MASK = 12'hf0f;

	// divider ratios
	localparam logic [7:0] PCC_RATIO_OFF = 8'h00;
	localparam logic [7:0] PCC_RATIO_ONE = 8'h01;
	localparam logic [7:0] PCC_RATIO_TWO = 8'h02;

	// clock source encoding shared by master and programmable clocks
	typedef enum logic [1:0] {
		PCC_SRC_SLOW = 2'b00,
		PCC_SRC_MAIN = 2'b01,
		PCC_SRC_PLL_A = 2'b10,
		PCC_SRC_PLL_B = 2'b11
	} pcc_src_t;

	// lock delay states
	typedef enum logic [0:0] {
		PCC_LT_WAIT = 1'b0,
		PCC_LT_LOCKED = 1'b1
	} pcc_lock_state_t;

endpackage : pcc_pkg

// *** rtl/pcc_clk_div.sv ***
// enable-pulse divider: off at ratio 0, bypass at 1, divide by ratio above
`timescale 1ns/1ps
module pcc_clk_div (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ref_en_i,
	input wire logic restart_i,
	input wire logic [7:0] ratio_i,
	output logic tick_o
);
	import pcc_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} pcc_div_state_t;

	pcc_div_state_t st;
	pcc_div_state_t next_st;

	// count reference pulses, emit one pulse every ratio of them
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (restart_i) begin
			next_st.cnt = 8'h00;
		end else if (ref_en_i && ratio_i != PCC_RATIO_OFF) begin
			if (st.cnt + 8'h01 >= ratio_i) begin
				next_st.cnt = 8'h00;
				next_st.tick = 1'b1;
			end else begin
				next_st.cnt = st.cnt + 8'h01;
			end
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_o = st.tick;

endmodule : pcc_clk_div

// *** rtl/pcc_lock_timer.sv ***
// pll lock delay: counts slow clock ticks after a configuration write
`timescale 1ns/1ps
module pcc_lock_timer (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic start_i,
	input wire logic [5:0] count_i,
	input wire logic slow_tick_i,
	output logic locked_o
);
	import pcc_pkg::*;

	typedef struct packed {
		pcc_lock_state_t state;
		logic [5:0] cnt;
	} pcc_lt_state_t;

	pcc_lt_state_t st;
	pcc_lt_state_t next_st;

	// a write reloads the delay and drops lock until it runs out
	always_comb begin
		next_st = st;
		if (start_i) begin
			next_st.state = PCC_LT_WAIT;
			next_st.cnt = count_i;
		end else begin
			unique case (st.state)
				PCC_LT_WAIT: begin
					if (st.cnt == 6'h00) begin
						next_st.state = PCC_LT_LOCKED;
					end else if (slow_tick_i) begin
						next_st.cnt = st.cnt - 6'h01;
					end
				end
				PCC_LT_LOCKED: begin
					next_st.state = PCC_LT_LOCKED;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st <= '{state: PCC_LT_WAIT, cnt: 6'h00};
		end else begin
			st <= next_st;
		end
	end

	assign locked_o = (st.state == PCC_LT_LOCKED);

endmodule : pcc_lock_timer

// *** rtl/pcc_top.sv ***
// pll, master clock and programmable clock configuration with avalon slave
// How it works
// - pll a divider: 0 off, 1 bypass, else divide
// - pll b divider: 0 off, 1 bypass, else divide
// - pll a locks after its count of slow ticks
// - pll b locks after its count of slow ticks
// - pll a multiplier zero deactivates, else times plus one
// - pll b multiplier zero deactivates, else times plus one
// - usb clock is pll b, or halved when selected
// - source select: slow, main, pll a, pll b
// - master prescaler divides by power of two, reserved code 7 stops it
// - processor ratio field sets processor clock multiple
// - four programmable clocks with source and prescaler
// - enable register sets mask bits on one
// - lock flags show lock state after delay
// - disable register clears mask bits on one
`timescale 1ns/1ps
module pcc_top (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [pcc_pkg::PCC_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic slow_clock_i,
	input wire logic osc_stable_i,
	input wire logic pll_a_clock_i,
	input wire logic pll_b_clock_i,
	output logic pll_a_ref_en_o,
	output logic pll_a_enable_o,
	output logic [10:0] pll_a_multiplier_o,
	output logic [1:0] pll_a_range_o,
	output logic pll_b_ref_en_o,
	output logic pll_b_enable_o,
	output logic [10:0] pll_b_multiplier_o,
	output logic [1:0] pll_b_range_o,
	output logic usb_clk_en_o,
	output logic master_clk_en_o,
	output logic [1:0] processor_ratio_o,
	output logic [3:0] prog_clk_en_o,
	output logic irq_o
);
	import pcc_pkg::*;

	// index of each external level in the synchroniser bank
	localparam int SYN_SLOW = 0;
	localparam int SYN_OSC = 1;
	localparam int SYN_PLL_A = 2;
	localparam int SYN_PLL_B = 3;

	typedef struct packed {
		logic [31:0] pll_a;
		logic [31:0] pll_b;
		logic [31:0] mckr;
		logic [3:0][4:0] pck;
		logic [11:0] mask;
		logic [11:0] events;
		logic [11:0] flags_prev;
		logic mck_rdy;
		logic [3:0] pck_rdy;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] level_prev;
		logic [31:0] rdata;
		logic done;
	} pcc_state_t;

	pcc_state_t st;
	pcc_state_t next_st;

	logic [3:0] rise;
	logic slow_tick;
	logic pll_a_tick;
	logic pll_b_tick;
	logic lock_a_raw;
	logic lock_b_raw;
	logic lock_a;
	logic lock_b;
	logic req;
	logic commit;
	logic wr_pll_a;
	logic wr_pll_b;
	logic wr_mckr;
	logic [3:0] wr_pck;
	logic mck_tick;
	logic [3:0] pck_tick;
	logic [11:0] flags;
	logic [3:0] src_ticks;
	logic [7:0] div_a;
	logic [7:0] div_b;
	logic [10:0] mul_a;
	logic [10:0] mul_b;

	// prescaler code to divider ratio; the reserved code stops the output
	function automatic logic [7:0] clock_prescaler_ratio(input logic [2:0] clock_prescaler);
		logic [7:0] r;
		r = PCC_RATIO_OFF;
		if (clock_prescaler != PCC_CLOCK_PRESCALER_RESERVED) begin
			r = 8'(PCC_RATIO_ONE << clock_prescaler);
		end
		return r;
	endfunction : clock_prescaler_ratio

	// source select picks one of the four source ticks
	function automatic logic pick_src(input logic [1:0] clock_source_select, input logic [3:0] ticks);
		logic t;
		t = 1'b0;
		unique case (pcc_src_t'(clock_source_select))
			PCC_SRC_SLOW: t = ticks[PCC_SRC_SLOW];
			PCC_SRC_MAIN: t = ticks[PCC_SRC_MAIN];
			PCC_SRC_PLL_A: t = ticks[PCC_SRC_PLL_A];
			PCC_SRC_PLL_B: t = ticks[PCC_SRC_PLL_B];
		endcase
		return t;
	endfunction : pick_src

	// rising edges of the synchronised external levels
	assign rise = st.sync2 & ~st.level_prev;
	assign slow_tick = rise[SYN_SLOW];

	// register field views
	assign div_a = st.pll_a[PCC_DIV_LSB +: 8];
	assign div_b = st.pll_b[PCC_DIV_LSB +: 8];
	assign mul_a = st.pll_a[PCC_MUL_LSB +: 11];
	assign mul_b = st.pll_b[PCC_MUL_LSB +: 11];

	// a pll output only counts while it is active and locked
	assign lock_a = lock_a_raw & (mul_a != 11'h000);
	assign lock_b = lock_b_raw & (mul_b != 11'h000);
	assign pll_a_tick = rise[SYN_PLL_A] & lock_a;
	assign pll_b_tick = rise[SYN_PLL_B] & lock_b;
	assign src_ticks = {pll_b_tick, pll_a_tick, 1'b1, slow_tick};

	// avalon handshake: one wait cycle, write commits when waitrequest drops
	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~st.done;
	assign commit = avs_write_i & st.done;
	assign wr_pll_a = commit && avs_address_i == PCC_PLL_A_CONFIG;
	assign wr_pll_b = commit && avs_address_i == PCC_PLL_B_CONFIG;
	assign wr_mckr = commit && avs_address_i == PCC_MASTER_CLOCK_SELECT;

	// live status flags in register layout
	always_comb begin
		flags = '0;
		flags[PCC_OSC_BIT] = st.sync2[SYN_OSC];
		flags[PCC_LOCK_A_BIT] = lock_a;
		flags[PCC_LOCK_B_BIT] = lock_b;
		flags[PCC_MCK_RDY_BIT] = st.mck_rdy;
		flags[PCC_PCK_RDY_LSB +: 4] = st.pck_rdy;
	end

	// pll lock delays, restarted by a configuration write
	pcc_lock_timer u_lock_a (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.start_i(wr_pll_a),
		.count_i(avs_writedata_i[PCC_CNT_LSB +: 6]),
		.slow_tick_i(slow_tick),
		.locked_o(lock_a_raw)
	);
	pcc_lock_timer u_lock_b (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.start_i(wr_pll_b),
		.count_i(avs_writedata_i[PCC_CNT_LSB +: 6]),
		.slow_tick_i(slow_tick),
		.locked_o(lock_b_raw)
	);

	// pll input dividers on the main clock
	pcc_clk_div u_div_a (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ref_en_i(1'b1),
		.restart_i(wr_pll_a),
		.ratio_i(div_a),
		.tick_o(pll_a_ref_en_o)
	);
	pcc_clk_div u_div_b (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ref_en_i(1'b1),
		.restart_i(wr_pll_b),
		.ratio_i(div_b),
		.tick_o(pll_b_ref_en_o)
	);

	// usb clock straight from pll b or halved
	pcc_clk_div u_div_usb (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ref_en_i(pll_b_tick),
		.restart_i(wr_pll_b),
		.ratio_i(st.pll_b[PCC_USB_BIT] ? PCC_RATIO_TWO : PCC_RATIO_ONE),
		.tick_o(usb_clk_en_o)
	);

	// master clock: selected source through the prescaler
	pcc_clk_div u_div_mck (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ref_en_i(pick_src(st.mckr[PCC_CSS_LSB +: 2], src_ticks)),
		.restart_i(wr_mckr),
		.ratio_i(clock_prescaler_ratio(st.mckr[PCC_CLOCK_PRESCALER_LSB +: 3])),
		.tick_o(mck_tick)
	);

	// programmable clocks, one register and divider each
	for (genvar g = 0; g < 4; g++) begin : g_pck
		assign wr_pck[g] = commit && avs_address_i == PCC_PROG_CLOCK0 + 6'(4 * g);
		pcc_clk_div u_div_pck (
			.clk_i(clk_i),
			.reset_n_i(reset_n_i),
			.ref_en_i(pick_src(st.pck[g][PCC_CSS_LSB +: 2], src_ticks)),
			.restart_i(wr_pck[g]),
			.ratio_i(clock_prescaler_ratio(st.pck[g][PCC_CLOCK_PRESCALER_LSB +: 3])),
			.tick_o(pck_tick[g])
		);
	end

	// next state: synchronisers, registers, readiness, events, read data
	always_comb begin
		next_st = st;
		next_st.sync1 = {pll_b_clock_i, pll_a_clock_i, osc_stable_i, slow_clock_i};
		next_st.sync2 = st.sync1;
		next_st.level_prev = st.sync2;
		next_st.done = req & ~st.done;

		// ready flags drop on a write and rise with the first new tick
		next_st.mck_rdy = (st.mck_rdy & ~wr_mckr) | mck_tick;
		next_st.pck_rdy = (st.pck_rdy & ~wr_pck) | pck_tick;

		// register writes
		if (wr_pll_a) begin
			next_st.pll_a = avs_writedata_i & PCC_PLL_A_MASK;
		end
		if (wr_pll_b) begin
			next_st.pll_b = avs_writedata_i & PCC_PLL_B_MASK;
		end
		if (wr_mckr) begin
			next_st.mckr = avs_writedata_i & PCC_MCKR_MASK;
		end
		for (int i = 0; i < 4; i++) begin
			if (wr_pck[i]) begin
				next_st.pck[i] = avs_writedata_i[4:0];
			end
		end
		if (commit && avs_address_i == PCC_INTERRUPT_ENABLE_SET) begin
			next_st.mask = st.mask | (avs_writedata_i[11:0] & PCC_FLAG_MASK);
		end
		if (commit && avs_address_i == PCC_INTERRUPT_DISABLE) begin
			next_st.mask = st.mask & ~avs_writedata_i[11:0];
		end

		// sticky events: a new rise wins over a clear in the same cycle
		next_st.flags_prev = flags;
		if (commit && avs_address_i == PCC_EVENT_CLEAR) begin
			next_st.events = st.events & ~avs_writedata_i[11:0];
		end
		next_st.events = next_st.events | (flags & ~st.flags_prev);

		// read data captured in the wait cycle
		if (avs_read_i && !st.done) begin
			unique case (avs_address_i)
				PCC_PLL_A_CONFIG: next_st.rdata = st.pll_a;
				PCC_PLL_B_CONFIG: next_st.rdata = st.pll_b;
				PCC_MASTER_CLOCK_SELECT: next_st.rdata = st.mckr;
				PCC_INTERRUPT_MASK: next_st.rdata = {20'h00000, st.mask};
				PCC_POWER_STATUS: next_st.rdata = {20'h00000, flags};
				PCC_EVENT_STATUS: next_st.rdata = {20'h00000, st.events};
				default: begin
					next_st.rdata = '0;
					for (int i = 0; i < 4; i++) begin
						if (avs_address_i == PCC_PROG_CLOCK0 + 6'(4 * i)) begin
							next_st.rdata = {27'h0000000, st.pck[i]};
						end
					end
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st <= '0;
			st.pll_a <= PCC_REG_RESET;
			st.pll_b <= PCC_REG_RESET;
			st.mckr <= PCC_REG_RESET;
			st.pck <= {4{PCC_PCK_RESET}};
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from registers
	assign avs_readdata_o = st.rdata;
	assign pll_a_enable_o = (mul_a != 11'h000);
	assign pll_b_enable_o = (mul_b != 11'h000);
	assign pll_a_multiplier_o = mul_a;
	assign pll_b_multiplier_o = mul_b;
	assign pll_a_range_o = st.pll_a[PCC_RANGE_LSB +: 2];
	assign pll_b_range_o = st.pll_b[PCC_RANGE_LSB +: 2];
	assign master_clk_en_o = mck_tick;
	assign processor_ratio_o = st.mckr[PCC_PROCESSOR_RATIO_LSB +: 2];
	assign prog_clk_en_o = pck_tick;
	assign irq_o = |(st.events & st.mask);

endmodule : pcc_top

// *** dv/pcc_props.sv ***
// concurrent checks on the ports of the pll and master clock block
`timescale 1ns/1ps
module pcc_props
	import pcc_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [PCC_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic slow_clock_i,
	input wire logic osc_stable_i,
	input wire logic pll_a_clock_i,
	input wire logic pll_b_clock_i,
	input wire logic pll_a_ref_en_o,
	input wire logic pll_a_enable_o,
	input wire logic [10:0] pll_a_multiplier_o,
	input wire logic [1:0] pll_a_range_o,
	input wire logic pll_b_ref_en_o,
	input wire logic pll_b_enable_o,
	input wire logic [10:0] pll_b_multiplier_o,
	input wire logic [1:0] pll_b_range_o,
	input wire logic usb_clk_en_o,
	input wire logic master_clk_en_o,
	input wire logic [1:0] processor_ratio_o,
	input wire logic [3:0] prog_clk_en_o,
	input wire logic irq_o
);
	logic wr_acc;
	logic [7:0] div_a;
	logic [7:0] div_b;
	logic [4:0] msel;
	logic [3:0] age;
	assign wr_acc = avs_write_i && !avs_waitrequest_o;
	// shadow of the written divider and master fields, age since the last write
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			div_a <= 8'h00;
			div_b <= 8'h00;
			msel <= 5'h00;
			age <= 4'h0;
		end else begin
			age <= wr_acc ? 4'h0 : age + {3'h0, age != 4'hf};
			if (wr_acc && avs_address_i == PCC_PLL_A_CONFIG) div_a <= avs_writedata_i[7:0];
			if (wr_acc && avs_address_i == PCC_PLL_B_CONFIG) div_b <= avs_writedata_i[7:0];
			if (wr_acc && avs_address_i == PCC_MASTER_CLOCK_SELECT) msel <= avs_writedata_i[4:0];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	chk_one_wait: assert property ($rose(avs_read_i || avs_write_i) |->
		avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait cycle wrong");
	chk_idle_ready: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
		else $error("wait while idle");
	chk_rdata_hold: assert property (!$past(avs_read_i) |-> $stable(avs_readdata_o))
		else $error("read data moved");
	chk_enable_a: assert property (pll_a_enable_o == (pll_a_multiplier_o != 11'h0))
		else $error("pll a enable wrong");
	chk_enable_b: assert property (pll_b_enable_o == (pll_b_multiplier_o != 11'h0))
		else $error("pll b enable wrong");
	chk_mul_write: assert property ($changed(pll_a_multiplier_o) |->
		$past(wr_acc && avs_address_i == PCC_PLL_A_CONFIG)) else $error("multiplier moved");
	chk_ratio_write: assert property ($changed(processor_ratio_o) |->
		$past(wr_acc && avs_address_i == PCC_MASTER_CLOCK_SELECT)) else $error("ratio moved");
	chk_pll_a_input_divider_off: assert property (age > 4'h4 && div_a == 8'h00 |-> !pll_a_ref_en_o)
		else $error("divider a not off");
	chk_pll_a_input_divider_pass: assert property (age > 4'h4 && div_a == 8'h01 |-> pll_a_ref_en_o)
		else $error("divider a not bypassed");
	chk_pll_b_input_divider_pass: assert property (age > 4'h4 && div_b == 8'h01 |-> pll_b_ref_en_o)
		else $error("divider b not bypassed");
	chk_mck_main: assert property (age > 4'h4 && msel == 5'h01 |-> master_clk_en_o)
		else $error("master not main clock");
	chk_mck_resv: assert property (age > 4'h4 && msel[4:2] == PCC_CLOCK_PRESCALER_RESERVED |->
		!master_clk_en_o) else $error("reserved prescaler ticks");
	cov_pll_write: cover property (wr_acc && avs_address_i == PCC_PLL_A_CONFIG);
	cov_irq_rise: cover property ($rose(irq_o));
	cov_clock_prescaler_64: cover property (msel[4:2] == 3'h6 && master_clk_en_o);
endmodule : pcc_props
bind pcc_top pcc_props i_pcc_props (.*);

// *** dv/tb_top.sv ***
// self-checking bench for the pll and master clock configuration block
`timescale 1ns/1ps
module tb_top;
	import pcc_pkg::*;
	logic clk_i, reset_n_i, avs_read_i, avs_write_i, slow_clock_i, osc_stable_i, irq_o;
	logic pll_a_clock_i, pll_b_clock_i, avs_waitrequest_o, usb_clk_en_o, master_clk_en_o;
	logic pll_a_ref_en_o, pll_a_enable_o, pll_b_ref_en_o, pll_b_enable_o;
	logic [5:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rng, q;
	logic [10:0] pll_a_multiplier_o, pll_b_multiplier_o;
	logic [1:0] pll_a_range_o, pll_b_range_o, processor_ratio_o;
	logic [3:0] prog_clk_en_o;
	logic [7:0] ph;
	logic [31:0] mdl [logic [5:0]];
	logic [5:0] rw_addr [7] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18};
	int rat [6] = '{0, 1, 2, 3, 5, 8};
	int bad_count, compares;
	int cnt [8];
	pcc_top i_pcc_top (.*);
	// free clock and pll pins rising every 8 and every 4 cycles
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		ph <= ph + 8'h01;
		pll_a_clock_i <= ph[2];
		pll_b_clock_i <= ph[1];
	end
	// pseudo random source and register masks
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0);
	endfunction : lfsr
	function automatic logic [31:0] rmask(input logic [5:0] a);
		if (a == PCC_PLL_A_CONFIG) return PCC_PLL_A_MASK;
		if (a == PCC_PLL_B_CONFIG) return PCC_PLL_B_MASK;
		if (a == PCC_MASTER_CLOCK_SELECT) return PCC_MCKR_MASK;
		return 32'h1f;
	endfunction : rmask
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one avalon transfer, held until waitrequest is sampled low
	task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		avs_writedata_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		q = avs_readdata_o;
		if (n >= 20) bad_count++;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (wr && mdl.exists(a)) mdl[a] = d & rmask(a);
	endtask : bus
	task count_all(input int win);
		repeat (10) @(posedge clk_i);
		cnt = '{default: 0};
		repeat (win) begin
			@(posedge clk_i);
			cnt[0] += pll_a_ref_en_o;
			cnt[1] += pll_b_ref_en_o;
			cnt[2] += usb_clk_en_o;
			cnt[3] += master_clk_en_o;
			for (int i = 0; i < 4; i++) cnt[4 + i] += prog_clk_en_o[i];
		end
	endtask : count_all
	task slow_ticks(input int n);
		repeat (n) begin
			@(posedge clk_i);
			slow_clock_i <= 1'b1;
			repeat (5) @(posedge clk_i);
			slow_clock_i <= 1'b0;
			repeat (5) @(posedge clk_i);
		end
	endtask : slow_ticks
	// configure a pll with a lock count of three slow ticks
	task lock_pll(input int b, input logic [31:0] cfg);
		bus(1'b1, b ? PCC_PLL_B_CONFIG : PCC_PLL_A_CONFIG, cfg);
		bus(1'b0, PCC_POWER_STATUS, 32'h0);
		check("lock", (q >> (1 + b)) & 32'h1, 32'h0);
		slow_ticks(2);
		bus(1'b0, PCC_POWER_STATUS, 32'h0);
		check("lock", (q >> (1 + b)) & 32'h1, 32'h0);
		slow_ticks(1);
		bus(1'b0, PCC_POWER_STATUS, 32'h0);
		check("lock", (q >> (1 + b)) & 32'h1, 32'h1);
	endtask : lock_pll
	task end_of_test();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (50000) @(posedge clk_i);
		bad_count++;
		end_of_test();
	end
	// main sequence
	initial begin
		{reset_n_i, avs_read_i, avs_write_i, slow_clock_i, osc_stable_i} = 5'h0;
		{pll_a_clock_i, pll_b_clock_i, avs_address_i, avs_writedata_i} = '0;
		{ph, bad_count, compares} = '0;
		rng = 32'he2a7;
		foreach (rw_addr[i]) mdl[rw_addr[i]] = 32'h0;
		repeat (6) @(posedge clk_i);
		reset_n_i <= 1'b1;
		for (int a = 0; a < 64; a += 4) begin
			if (a == 6'h28 || a == 6'h2c) continue;
			bus(1'b0, 6'(a), 32'h0);
			check("reset", q, mdl.exists(6'(a)) ? mdl[6'(a)] : 32'h0);
		end
		$display("test reset done");
		foreach (rw_addr[i]) begin
			rng = lfsr(rng);
			bus(1'b1, rw_addr[i], rng & 32'hffff_bfff); // range code 00 or 10 only
			bus(1'b0, rw_addr[i], 32'h0);
			check("readback", q, mdl[rw_addr[i]]);
		end
		check("mul_a", 32'(pll_a_multiplier_o), (mdl[6'h00] >> 16) & 32'h7ff);
		check("range_b", 32'(pll_b_range_o), (mdl[6'h04] >> 14) & 32'h3);
		check("range_a", 32'(pll_a_range_o), (mdl[6'h00] >> 14) & 32'h3);
		check("mul_b", 32'(pll_b_multiplier_o), (mdl[6'h04] >> 16) & 32'h7ff);
		check("enable_a", 32'(pll_a_enable_o), 32'(|mdl[6'h00][26:16]));
		check("enable_b", 32'(pll_b_enable_o), 32'(|mdl[6'h04][26:16]));
		check("ratio", 32'(processor_ratio_o), (mdl[6'h08] >> 8) & 32'h3);
		bus(1'b1, 6'h3c, rng);
		bus(1'b0, 6'h3c, 32'h0);
		check("unmapped", q, 32'h0);
		$display("test readback done");
		foreach (rat[i]) begin
			bus(1'b1, PCC_PLL_A_CONFIG, 32'h0001_0000 | 32'(rat[i]));
			bus(1'b1, PCC_PLL_B_CONFIG, 32'h0001_0000 | 32'(rat[i]));
			count_all(120);
			check("div_a", cnt[0], rat[i] ? 120 / rat[i] : 0);
			check("div_b", cnt[1], rat[i] ? 120 / rat[i] : 0);
		end
		$display("test dividers done");
		lock_pll(0, 32'h0001_0301);
		lock_pll(1, 32'h0001_0301);
		bus(1'b1, PCC_MASTER_CLOCK_SELECT, 32'h2); // value differs from the last
		count_all(128);
		check("mck_pll_a", cnt[3], 16);
		bus(1'b1, PCC_MASTER_CLOCK_SELECT, 32'h3);
		count_all(128);
		check("mck_pll_b", cnt[3], 32);
		check("usb_full", cnt[2], 32);
		lock_pll(1, 32'h1001_0301);
		count_all(128);
		check("usb_half", cnt[2], 16);
		bus(1'b1, PCC_MASTER_CLOCK_SELECT, 32'h0); // slow source, differs from the last
		fork
			slow_ticks(4);
			count_all(50);
		join
		check("mck_slow", cnt[3], 3);
		$display("test lock done");
		for (int p = 0; p < 8; p++) begin
			bus(1'b1, PCC_MASTER_CLOCK_SELECT, 32'(p * 4 + 1));
			for (int i = 0; i < 4; i++) bus(1'b1, 6'(12 + 4 * i), 32'(p * 4 + 1));
			count_all(128);
			check("mck_clock_prescaler", cnt[3], p == 7 ? 0 : 128 >> p);
			for (int i = 0; i < 4; i++) check("pck_clock_prescaler", cnt[4 + i], p == 7 ? 0 : 128 >> p);
		end
		$display("test prescaler done");
		bus(1'b1, PCC_EVENT_CLEAR, 32'hfff);
		bus(1'b1, PCC_INTERRUPT_ENABLE_SET, 32'h1);
		bus(1'b0, PCC_INTERRUPT_MASK, 32'h0);
		check("mask", q, 32'h1);
		check("irq", 32'(irq_o), 32'h0);
		osc_stable_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		check("irq", 32'(irq_o), 32'h1);
		bus(1'b1, PCC_INTERRUPT_ENABLE_SET, 32'h0);
		bus(1'b1, PCC_INTERRUPT_DISABLE, 32'h0);
		bus(1'b0, PCC_INTERRUPT_MASK, 32'h0);
		check("mask", q, 32'h1);
		bus(1'b1, PCC_INTERRUPT_DISABLE, 32'h1);
		bus(1'b0, PCC_INTERRUPT_MASK, 32'h0);
		check("mask", q, 32'h0);
		check("irq", 32'(irq_o), 32'h0);
		bus(1'b1, PCC_INTERRUPT_ENABLE_SET, 32'h101);
		bus(1'b1, PCC_EVENT_CLEAR, 32'h1);
		bus(1'b0, PCC_EVENT_STATUS, 32'h0);
		check("irq", 32'(irq_o), 32'h0);
		bus(1'b1, PCC_PROG_CLOCK0, 32'h1);
		repeat (10) @(posedge clk_i);
		check("irq", 32'(irq_o), 32'h1);
		bus(1'b0, PCC_EVENT_STATUS, 32'h0);
		check("event", q & 32'h101, 32'h100);
		$display("test interrupt done");
		end_of_test();
	end
endmodule : tb_top
